// ===== rtl/tlq_led_fade.v
// One LED driver: a 256-step PWM generator with instant turn-on and logarithmic fade-out.
// Assumes a synchronous active-high reset and a one-cycle fade step pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "tlq_map.vh"

module tlq_led_fade (
    // Clock and reset.
    input wire i_clk,
    input wire i_rst,
    // Control.
    input wire i_on,
    input wire i_step,
    // LED drive.
    output reg o_pwm
);
    // Present intensity of the LED.
    reg [7:0] level;
    // Free-running PWM phase counter.
    reg [7:0] phase;
    // Amount removed on one fade step.
    wire [7:0] decay = level >> `TLQ_FADE_SHIFT;
    // Intensity after one fade step; small levels still fall by one so the LED goes dark.
    wire [7:0] next_level = (decay == 8'h00 && level != `TLQ_LEVEL_OFF) ?
        (level - 8'h01) : (level - decay);

    // Jumps to full at touch and decays by a fixed fraction each step after release.
    always @(posedge i_clk) begin
        if (i_rst) begin
            level <= `TLQ_LEVEL_OFF;
            phase <= 8'h00;
            o_pwm <= 1'b0;
        end else begin
            phase <= phase + 8'h01;
            if (i_on) begin
                level <= `TLQ_LEVEL_FULL; // [RULE2]
            end else if (i_step) begin
                level <= next_level; // [RULE3]
            end
            o_pwm <= (phase < level); // [RULE1]
        end
    end
endmodule // tlq_led_fade
`default_nettype wire

// ===== rtl/tlq_map.vh
// Constants for the touch-to-light quick-start block: timing, detection and pin encodings.
// Assumes a 10 MHz system clock; included by rtl/tlq_quickstart.v and rtl/tlq_led_fade.v.
`ifndef TLQ_MAP_VH
`define TLQ_MAP_VH

// System clock period in nanoseconds.
`define TLQ_CLK_NS 100
// Longest time from reset to releasing the interrupt line, in milliseconds.
`define TLQ_STARTUP_MS 150
// Cycles for that time, rounded down so the release is never late.
`define TLQ_STARTUP_CYCLES ((`TLQ_STARTUP_MS * 1000000) / `TLQ_CLK_NS)
// Time between two fade steps, in nanoseconds.
`define TLQ_FADE_STEP_NS 2000000
// Cycles between two fade steps.
`define TLQ_FADE_STEP_CYCLES (`TLQ_FADE_STEP_NS / `TLQ_CLK_NS)

// Number of sense inputs and LED pins.
`define TLQ_NUM_CH 8
// Width of one tick count from the charge-to-tick front end.
`define TLQ_TICK_W 10
// Touch threshold and hysteresis in ticks.
`define TLQ_THRESHOLD 10'h0_200
`define TLQ_HYSTERESIS 10'h0_020
// First sense input of the slider and number of slider inputs.
`define TLQ_SLIDER_BASE 2
`define TLQ_SLIDER_LEN 6

// LED fade levels: full on and off.
`define TLQ_LEVEL_FULL 8'hFF
`define TLQ_LEVEL_OFF 8'h00
// Right shift that sets the logarithmic decay rate per fade step.
`define TLQ_FADE_SHIFT 3

// Default 7-bit host port address; the value is arbitrary.
`define TLQ_I2C_ADDR 7'h2_B

// Status byte field positions.
`define TLQ_ST_BTN0 0
`define TLQ_ST_BTN1 1
`define TLQ_ST_SLIDER 2
`define TLQ_ST_SLEEP 7

`endif

// ===== rtl/tlq_quickstart.v
// Quick-start touch controller core: touch detection, slider, LED drive and host status port.
// Assumes tick counts come from a front end on I_CLOCK; pins SCL, SDA and reset are asynchronous.
//
// Behaviour
// [RULE1] Two buttons, six-input slider, eight fading LEDs.
// [RULE2] Touch on input zero lights LED zero.
// [RULE3] Release of input zero fades LED logarithmically.
// [RULE4] LED one follows input one touch state.
// [RULE5] Inputs two to seven form slider showing position.
// [RULE6] Touch and fading run without any host.
// [RULE7] Front end gives tick counts rising with charge.
// [RULE8] Interrupt asserted whenever new status is pending.
// [RULE9] Each button reports only touched or released.
// [RULE10] Host port is slave; master clocks 400 kHz maximum.
// [RULE11] Interrupt released high within 150 ms after start.
// [RULE12] Sleep stops scanning; host port stays responsive.
// [RULE13] Interrupt is active low, open drain.
// [RULE14] Hardware reset pin is active low.
// [RULE15] Host status read clears the interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "tlq_map.vh"

module tlq_quickstart #(
    parameter STARTUP_CYCLES = `TLQ_STARTUP_CYCLES,
    parameter FADE_STEP_CYCLES = `TLQ_FADE_STEP_CYCLES
) (
    // System clock and reset.
    input wire I_CLOCK,
    input wire I_SYS_RST,
    // Hardware reset pin, active low.
    input wire I_HW_RESET_N,
    // Sense front end: eight packed tick counts and a sample strobe.
    input wire [`TLQ_NUM_CH*`TLQ_TICK_W-1:0] I_SENSE_TICKS,
    input wire I_SENSE_VALID,
    // Sleep request level.
    input wire I_SLEEP,
    // Host port serial clock and data.
    input wire I_SCL,
    input wire I_SDA_IN,
    output wire O_SDA_OUT,
    output wire O_SDA_OE,
    // Interrupt line, open drain.
    output wire O_HOST_IRQ_N_OUT,
    output wire O_HOST_IRQ_N_OE,
    // LED pins.
    output wire [`TLQ_NUM_CH-1:0] O_LED_PIN
);
    // Host port states.
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_AACK = 3'd2;
    localparam [2:0] ST_READ = 3'd3;
    localparam [2:0] ST_RACK = 3'd4;
    localparam [2:0] ST_WRITE = 3'd5;
    localparam [2:0] ST_WACK = 3'd6;

    // Two-stage synchronisers for the reset, SCL and SDA pins.
    reg rst_n_s1, rst_n_s2;
    reg scl_s1, scl_s2, scl_d;
    reg sda_s1, sda_s2, sda_d;
    // Internal reset combines the system reset and the pin.
    wire rst = I_SYS_RST | ~rst_n_s2;

    // Pin synchronisers; only the second stage is read by logic.
    always @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            rst_n_s1 <= 1'b0;
            rst_n_s2 <= 1'b0;
        end else begin
            rst_n_s1 <= I_HW_RESET_N; // [RULE14]
            rst_n_s2 <= rst_n_s1;
        end
    end

    // Serial pins idle high, so they reset to one.
    always @(posedge I_CLOCK) begin
        if (rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= I_SCL;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= I_SDA_IN;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    // Bus events seen on the synchronised lines.
    wire scl_rise = scl_s2 & ~scl_d;
    wire scl_fall = ~scl_s2 & scl_d;
    wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

    // Start-up counter and done flag.
    reg [23:0] start_cnt;
    reg start_done;

    // Holds the interrupt line low until start-up time has passed.
    always @(posedge I_CLOCK) begin
        if (rst) begin
            start_cnt <= 24'h00_0000;
            start_done <= 1'b0;
        end else if (!start_done) begin
            if (start_cnt == STARTUP_CYCLES[23:0] - 24'h00_0001) begin
                start_done <= 1'b1; // [RULE11]
            end
            start_cnt <= start_cnt + 24'h00_0001;
        end
    end

    // Touch state per input.
    reg [`TLQ_NUM_CH-1:0] touched;
    // A new sample is processed only outside sleep.
    wire scan = I_SENSE_VALID & ~I_SLEEP; // [RULE12]

    // Touch state that each input takes from the sample now present.
    wire [`TLQ_NUM_CH-1:0] next_touched;

    // Per-input detection with hysteresis around the threshold.
    genvar g;
    generate
        for (g = 0; g < `TLQ_NUM_CH; g = g + 1) begin : g_det
            wire [`TLQ_TICK_W-1:0] ticks = I_SENSE_TICKS[g*`TLQ_TICK_W +: `TLQ_TICK_W]; // [RULE7]
            // Touch at threshold plus hysteresis, release below threshold minus it, else hold.
            assign next_touched[g] = (ticks >= `TLQ_THRESHOLD + `TLQ_HYSTERESIS) |
                (touched[g] & ~(ticks < `TLQ_THRESHOLD - `TLQ_HYSTERESIS)); // [RULE9]
        end
    endgenerate

    // Takes the new touch state of all inputs on every accepted scan.
    always @(posedge I_CLOCK) begin
        if (rst) begin
            touched <= {`TLQ_NUM_CH{1'b0}};
        end else if (scan) begin
            touched <= next_touched;
        end
    end

    // Slider: index of the strongest touched slider input.
    reg [2:0] best_idx;
    reg [`TLQ_TICK_W-1:0] best_ticks;
    integer k;

    // Finds the slider input with the largest tick count among those touched.
    always @* begin
        best_idx = 3'd0;
        best_ticks = {`TLQ_TICK_W{1'b0}};
        for (k = 0; k < `TLQ_SLIDER_LEN; k = k + 1) begin
            if (next_touched[`TLQ_SLIDER_BASE + k] &&
                I_SENSE_TICKS[(`TLQ_SLIDER_BASE + k)*`TLQ_TICK_W +: `TLQ_TICK_W] > best_ticks) begin
                best_ticks = I_SENSE_TICKS[(`TLQ_SLIDER_BASE + k)*`TLQ_TICK_W +: `TLQ_TICK_W];
                best_idx = k[2:0];
            end
        end
    end

    // Slider finger present and its registered position.
    wire slider_on = |touched[`TLQ_SLIDER_BASE +: `TLQ_SLIDER_LEN];
    // Finger on the slider in the sample now present.
    wire next_slider_on = |next_touched[`TLQ_SLIDER_BASE +: `TLQ_SLIDER_LEN];
    reg [2:0] slider_pos;

    // Captures the position from the same scan that sets the touch, so it never lags a scan.
    always @(posedge I_CLOCK) begin
        if (rst) begin
            slider_pos <= 3'd0;
        end else if (scan && next_slider_on) begin
            slider_pos <= best_idx; // [RULE5]
        end
    end

    // LED commands: buttons follow their inputs, slider lights the position LED.
    wire [`TLQ_NUM_CH-1:0] led_on;
    assign led_on[0] = touched[0]; // [RULE2]
    assign led_on[1] = touched[1]; // [RULE4]
    generate
        for (g = 0; g < `TLQ_SLIDER_LEN; g = g + 1) begin : g_sld
            assign led_on[`TLQ_SLIDER_BASE + g] = slider_on && (slider_pos == g); // [RULE5]
        end
    endgenerate

    // Fade step prescaler shared by all LEDs.
    reg [23:0] fade_cnt;
    reg fade_step;

    // Emits one step pulse every fade interval, independent of the host.
    always @(posedge I_CLOCK) begin
        if (rst) begin
            fade_cnt <= 24'h00_0000;
            fade_step <= 1'b0;
        end else if (fade_cnt == FADE_STEP_CYCLES[23:0] - 24'h00_0001) begin
            fade_cnt <= 24'h00_0000;
            fade_step <= 1'b1; // [RULE6]
        end else begin
            fade_cnt <= fade_cnt + 24'h00_0001;
            fade_step <= 1'b0;
        end
    end

    // Eight independent PWM fade generators.
    generate
        for (g = 0; g < `TLQ_NUM_CH; g = g + 1) begin : g_led
            tlq_led_fade u_fade (
                .i_clk(I_CLOCK),
                .i_rst(rst),
                .i_on(led_on[g]),
                .i_step(fade_step),
                .o_pwm(O_LED_PIN[g])
            ); // [RULE1]
        end
    endgenerate

    // Status byte and change detection.
    wire [7:0] status = {I_SLEEP, 4'h0, slider_on, touched[1], touched[0]};
    reg [7:0] status_last;
    reg [2:0] pos_last;
    wire news = (status != status_last) || (slider_on && slider_pos != pos_last);

    // Host port state.
    reg [2:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg [7:0] txreg;
    reg rw_read;
    reg byte_idx;
    reg sda_drive;
    reg pending;
    // First status byte fully sent: the read that clears the interrupt.
    wire status_read = (state == ST_READ) && scl_fall && (bitcnt == 4'd7) && !byte_idx;

    // Pending flag; a new event in the clearing cycle wins.
    always @(posedge I_CLOCK) begin
        if (rst) begin
            pending <= 1'b0;
            status_last <= 8'h00;
            pos_last <= 3'd0;
        end else begin
            status_last <= status;
            pos_last <= slider_pos;
            if (news) begin
                pending <= 1'b1; // [RULE8]
            end else if (status_read) begin
                pending <= 1'b0; // [RULE15]
            end
        end
    end

    // Host port slave: sample on SCL rise, change SDA on SCL fall.
    always @(posedge I_CLOCK) begin
        if (rst) begin
            state <= ST_IDLE;
            bitcnt <= 4'd0;
            shreg <= 8'h00;
            txreg <= 8'h00;
            rw_read <= 1'b0;
            byte_idx <= 1'b0;
            sda_drive <= 1'b0;
        end else if (bus_start) begin
            state <= ST_ADDR; // [RULE10]
            bitcnt <= 4'd0;
            sda_drive <= 1'b0;
        end else if (bus_stop) begin
            state <= ST_IDLE;
            sda_drive <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_WRITE: begin
                    // Shift in eight bits, then acknowledge data or a matching address on the following fall.
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s2};
                        bitcnt <= bitcnt + 4'd1;
                    end else if (scl_fall && bitcnt == 4'd8) begin
                        bitcnt <= 4'd0;
                        if (state == ST_WRITE) begin
                            sda_drive <= 1'b1;
                            state <= ST_WACK;
                        end else if (shreg[7:1] == `TLQ_I2C_ADDR) begin
                            sda_drive <= 1'b1;
                            rw_read <= shreg[0];
                            byte_idx <= 1'b0;
                            state <= ST_AACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_AACK, ST_WACK: begin
                    // Release the acknowledge, or present the first read bit.
                    if (scl_fall) begin
                        if (state == ST_AACK && rw_read) begin
                            txreg <= status;
                            sda_drive <= ~status[7];
                            state <= ST_READ;
                        end else begin
                            sda_drive <= 1'b0;
                            state <= ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    // Shift out the byte most significant bit first.
                    if (scl_fall) begin
                        if (bitcnt == 4'd7) begin
                            bitcnt <= 4'd0;
                            sda_drive <= 1'b0;
                            state <= ST_RACK;
                        end else begin
                            bitcnt <= bitcnt + 4'd1;
                            txreg <= {txreg[6:0], 1'b0};
                            sda_drive <= ~txreg[6];
                        end
                    end
                end
                ST_RACK: begin
                    // Master acknowledge continues with the next byte; no acknowledge ends.
                    if (scl_rise && sda_s2) begin
                        state <= ST_IDLE;
                    end else if (scl_fall) begin
                        byte_idx <= ~byte_idx;
                        txreg <= byte_idx ? status : {5'h00, slider_pos};
                        sda_drive <= byte_idx ? ~status[7] : 1'b1;
                        state <= ST_READ;
                    end
                end
                default: begin
                    sda_drive <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain outputs only ever pull low.
    assign O_SDA_OUT = 1'b0;
    assign O_SDA_OE = sda_drive;
    assign O_HOST_IRQ_N_OUT = 1'b0; // [RULE13]
    assign O_HOST_IRQ_N_OE = ~start_done | pending; // [RULE11]
endmodule // tlq_quickstart
`default_nettype wire

// ===== verif/tlq_chk.sv
// Checker for tlq_quickstart: open-drain levels, start-up release, touch, fade and reset.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "tlq_map.vh"

module tlq_chk #(
    parameter int STARTUP_CYCLES = 50,
    parameter int FADE_STEP_CYCLES = 64
) (
    // Inputs of the block.
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    input wire logic I_HW_RESET_N,
    input wire logic [`TLQ_NUM_CH*`TLQ_TICK_W-1:0] I_SENSE_TICKS,
    input wire logic I_SENSE_VALID,
    input wire logic I_SLEEP,
    // Outputs of the block.
    input wire logic O_SDA_OUT,
    input wire logic O_SDA_OE,
    input wire logic O_HOST_IRQ_N_OUT,
    input wire logic O_HOST_IRQ_N_OE,
    input wire logic [`TLQ_NUM_CH-1:0] O_LED_PIN
);
    localparam int SU_LIM = STARTUP_CYCLES + 6; // Start-up end plus synchroniser margin.
    localparam int OFF_LIM = 64 * FADE_STEP_CYCLES + 300; // 64 fade steps, above the 38 a full fade takes, plus one PWM period.
    int su_cnt; // Cycles since reset, saturating.
    int off_cnt; // Cycles input zero has been released, saturating.
    logic quiet; // No scan and no sleep since reset, so nothing can be pending.
    logic t0; // Touch state of input zero.
    wire rst_any = I_SYS_RST || !I_HW_RESET_N;
    wire scan = I_SENSE_VALID && !I_SLEEP;
    wire new_t0 = scan && !t0 && I_SENSE_TICKS[9:0] >= 10'h220;

    // Tracks input zero with the same hysteresis, so touch and release moments are known.
    always @(posedge I_CLOCK) begin
        if (rst_any) begin
            su_cnt <= 0;
            off_cnt <= 0;
            quiet <= 1'b1;
            t0 <= 1'b0;
        end else begin
            su_cnt <= (su_cnt == SU_LIM) ? su_cnt : su_cnt + 1;
            off_cnt <= t0 ? 0 : ((off_cnt == OFF_LIM) ? off_cnt : off_cnt + 1);
            quiet <= quiet && !I_SENSE_VALID && !I_SLEEP;
            t0 <= new_t0 ? 1'b1 : ((scan && I_SENSE_TICKS[9:0] < 10'h1E0) ? 1'b0 : t0);
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (rst_any);

    property p_od_low; !O_HOST_IRQ_N_OUT && !O_SDA_OUT; endproperty
    a_od_low: assert property (p_od_low) else $error("open drain output drove high");
    property p_rst_out; disable iff (!I_HW_RESET_N)
        I_SYS_RST |=> O_HOST_IRQ_N_OE && !O_SDA_OE && O_LED_PIN == 8'h00; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not reset");
    property p_su_hold; su_cnt >= 1 && su_cnt < STARTUP_CYCLES |-> O_HOST_IRQ_N_OE; endproperty
    a_su_hold: assert property (p_su_hold) else $error("interrupt released early");
    property p_su_rel; su_cnt == SU_LIM && quiet |-> !O_HOST_IRQ_N_OE; endproperty
    a_su_rel: assert property (p_su_rel) else $error("interrupt not released");
    property p_touch_irq; new_t0 |-> ##[1:3] O_HOST_IRQ_N_OE; endproperty
    a_touch_irq: assert property (p_touch_irq) else $error("touch raised no interrupt");
    property p_touch_led; new_t0 |-> ##[1:300] O_LED_PIN[0]; endproperty
    a_touch_led: assert property (p_touch_led) else $error("touch did not light led");
    property p_fade_glow; $fell(t0) && su_cnt == SU_LIM |-> ##[1:260] O_LED_PIN[0]; endproperty
    a_fade_glow: assert property (p_fade_glow) else $error("led went dark at once");
    property p_fade_off; off_cnt == OFF_LIM |-> !O_LED_PIN[0]; endproperty
    a_fade_off: assert property (p_fade_off) else $error("led still lit");
    property p_hw_rst; disable iff (I_SYS_RST) $fell(I_HW_RESET_N) ##1 !I_HW_RESET_N ##1
        !I_HW_RESET_N |-> ##[0:2] (O_HOST_IRQ_N_OE && O_LED_PIN == 8'h00 && !O_SDA_OE); endproperty
    a_hw_rst: assert property (p_hw_rst) else $error("reset pin had no effect");

    // Main scenarios reached.
    c_touch: cover property (new_t0);
    c_sleep_scan: cover property (I_SLEEP && I_SENSE_VALID);
    c_ack: cover property (O_SDA_OE);
endmodule // tlq_chk

bind tlq_quickstart tlq_chk #(
    .STARTUP_CYCLES(STARTUP_CYCLES),
    .FADE_STEP_CYCLES(FADE_STEP_CYCLES)
) u_tlq_chk (
    .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_HW_RESET_N(I_HW_RESET_N),
    .I_SENSE_TICKS(I_SENSE_TICKS), .I_SENSE_VALID(I_SENSE_VALID), .I_SLEEP(I_SLEEP),
    .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .O_HOST_IRQ_N_OUT(O_HOST_IRQ_N_OUT),
    .O_HOST_IRQ_N_OE(O_HOST_IRQ_N_OE), .O_LED_PIN(O_LED_PIN)
);
`default_nettype wire

// ===== verif/tlq_host_model.sv
// Host model: a serial-bus master that reads the status and slider bytes.
// Assumes a pulled-up SDA wire formed outside from both sides' pull-down enables.
`timescale 1ns/1ps
`default_nettype none

module tlq_host_model #(
    parameter int HALF_NS = 400
) (
    // Serial bus pins.
    output var logic o_scl,
    output var logic o_sda_oe,
    input wire logic i_sda
);
    // The bus idles with SCL standing high and SDA released.
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end

    // One bit: data changes while SCL is low and is read late in the high phase.
    task automatic bit_cyc(input logic b, input int slow, output logic r);
        o_sda_oe = !b;
        #(HALF_NS * (1 + slow));
        o_scl = 1'b1;
        #(HALF_NS - 20);
        r = i_sda;
        #20;
        o_scl = 1'b0;
    endtask

    // Whole read: START, address with read bit, two bytes when acknowledged, STOP.
    task automatic xfer(input logic [6:0] addr, input int slow, output logic ack,
                        output logic [7:0] st, output logic [7:0] sl);
        logic r;
        logic [7:0] a;
        a = {addr, 1'b1};
        st = 8'h00;
        sl = 8'h00;
        #37;
        o_sda_oe = 1'b1;
        #(HALF_NS);
        o_scl = 1'b0;
        for (int i = 7; i >= 0; i--) bit_cyc(a[i], slow, r);
        bit_cyc(1'b1, slow, r);
        ack = !r;
        if (ack) begin
            for (int i = 7; i >= 0; i--) bit_cyc(1'b1, slow, st[i]);
            bit_cyc(1'b0, slow, r);
            for (int i = 7; i >= 0; i--) bit_cyc(1'b1, slow, sl[i]);
            bit_cyc(1'b1, slow, r);
        end
        o_sda_oe = 1'b1;
        #(HALF_NS);
        o_scl = 1'b1;
        #(HALF_NS);
        o_sda_oe = 1'b0;
        #(2 * HALF_NS);
    endtask
endmodule // tlq_host_model
`default_nettype wire

// ===== verif/tlq_quickstart_tb_top.sv
// Testbench for tlq_quickstart: sense scans driven here, host reads through the host model.
// Assumes the design, the checker and the host model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "tlq_map.vh"

module tlq_quickstart_tb_top;
    localparam int SU = 50; // Shortened start-up time in cycles.
    logic I_CLOCK, I_SYS_RST, I_HW_RESET_N, I_SENSE_VALID, I_SLEEP;
    logic [`TLQ_NUM_CH*`TLQ_TICK_W-1:0] I_SENSE_TICKS;
    wire O_SDA_OUT, O_SDA_OE, O_HOST_IRQ_N_OUT, O_HOST_IRQ_N_OE, scl, host_oe;
    wire [`TLQ_NUM_CH-1:0] O_LED_PIN;
    wire sda = !(host_oe || O_SDA_OE); // Pulled up, low while either side pulls.
    int error_cnt = 0;
    int checks = 0;
    logic [7:0] st, sl, s;
    logic ack;

    tlq_quickstart #(.STARTUP_CYCLES(SU), .FADE_STEP_CYCLES(64)) u_tlq_quickstart (
        .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_HW_RESET_N(I_HW_RESET_N),
        .I_SENSE_TICKS(I_SENSE_TICKS), .I_SENSE_VALID(I_SENSE_VALID), .I_SLEEP(I_SLEEP),
        .I_SCL(scl), .I_SDA_IN(sda), .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE),
        .O_HOST_IRQ_N_OUT(O_HOST_IRQ_N_OUT), .O_HOST_IRQ_N_OE(O_HOST_IRQ_N_OE),
        .O_LED_PIN(O_LED_PIN));
    tlq_host_model #(.HALF_NS(400)) u_tlq_host_model (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda));

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits n edges, then lets their updates land.
    task automatic cyc(input int n);
        repeat (n) @(posedge I_CLOCK);
        #1;
    endtask

    task automatic irq(input logic e);
        check({7'h0, O_HOST_IRQ_N_OE}, {7'h0, e});
    endtask

    // One scan with up to two non-zero channels, then time for status to settle.
    task automatic scan(input int ca, input logic [9:0] va, input int cb, input logic [9:0] vb);
        @(posedge I_CLOCK);
        I_SENSE_TICKS <= (80'(va) << (10 * ca)) | (80'(vb) << (10 * cb));
        I_SENSE_VALID <= 1'b1;
        @(posedge I_CLOCK);
        I_SENSE_VALID <= 1'b0;
        cyc(4);
    endtask

    // Collects every LED pin seen high over one PWM period.
    task automatic leds(input logic [7:0] exp);
        s = 8'h00;
        repeat (260) begin
            @(posedge I_CLOCK);
            #1 s = s | O_LED_PIN;
        end
        check(s, exp);
    endtask

    // Host read; a negative slider value skips that byte's comparison.
    task automatic rd(input logic [7:0] es, input int esl, input int slow);
        u_tlq_host_model.xfer(`TLQ_I2C_ADDR, slow, ack, st, sl);
        cyc(6);
        check({7'h0, ack}, 8'h01);
        check(st, es);
        if (esl >= 0) check(sl, 8'(esl));
        irq(1'b0);
    endtask

    // Reset holds the interrupt low; start-up then releases it.
    task automatic t_startup();
        check({6'h0, O_HOST_IRQ_N_OE, O_SDA_OE}, 8'h02);
        check(O_LED_PIN, 8'h00);
        @(posedge I_CLOCK);
        I_SYS_RST <= 1'b0;
        cyc(SU - 10);
        irq(1'b1);
        cyc(20);
        irq(1'b0);
        check({6'h0, O_HOST_IRQ_N_OUT, O_SDA_OUT}, 8'h00);
    endtask

    // Button zero: touch, hold inside the hysteresis band, release with fade.
    task automatic t_btn0();
        scan(0, 10'h220, 0, 10'h000);
        irq(1'b1);
        leds(8'h01);
        rd(8'h01, 0, 0);
        scan(0, 10'h1E0, 0, 10'h000);
        irq(1'b0);
        scan(0, 10'h1DF, 0, 10'h000);
        irq(1'b1);
        leds(8'h01);
        cyc(3000);
        leds(8'h00);
        rd(8'h00, 0, 0);
    endtask

    // Button one just below and at threshold plus hysteresis, read by a slow host.
    task automatic t_btn1();
        scan(1, 10'h21F, 1, 10'h000);
        irq(1'b0);
        scan(1, 10'h220, 1, 10'h000);
        leds(8'h02);
        rd(8'h02, 0, 1);
        scan(1, 10'h000, 1, 10'h000);
        rd(8'h00, 0, 0);
        cyc(3000);
    endtask

    // Slider: largest count wins, a tie goes to the lower position.
    task automatic t_slider();
        scan(3, 10'h300, 5, 10'h350);
        leds(8'h20);
        rd(8'h04, 3, 0);
        scan(2, 10'h300, 4, 10'h300);
        rd(8'h04, 0, 0);
        scan(2, 10'h000, 2, 10'h000);
        rd(8'h00, -1, 0);
        cyc(3000);
    endtask

    // Sleep ignores scans while the host port keeps answering.
    task automatic t_sleep();
        @(posedge I_CLOCK);
        I_SLEEP <= 1'b1;
        cyc(4);
        irq(1'b1);
        scan(0, 10'h300, 0, 10'h000);
        leds(8'h00);
        rd(8'h80, -1, 0);
        @(posedge I_CLOCK);
        I_SLEEP <= 1'b0;
        cyc(4);
        rd(8'h00, -1, 0);
    endtask

    // A foreign address gets no acknowledge; the reset pin clears everything.
    task automatic t_addr_pin();
        u_tlq_host_model.xfer(7'h2C, 0, ack, st, sl);
        check({7'h0, ack}, 8'h00);
        scan(1, 10'h220, 1, 10'h000);
        @(posedge I_CLOCK);
        I_HW_RESET_N <= 1'b0;
        cyc(6);
        check({6'h0, O_HOST_IRQ_N_OE, O_SDA_OE}, 8'h02);
        check(O_LED_PIN, 8'h00);
        @(posedge I_CLOCK);
        I_HW_RESET_N <= 1'b1;
        cyc(SU + 20);
        rd(8'h00, 0, 0);
    endtask

    initial begin
        I_CLOCK = 1'b0;
        forever #50 I_CLOCK = ~I_CLOCK;
    end

    // Cuts a hang short well after the expected run length.
    initial begin
        #10_000_000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        I_SYS_RST = 1'b1;
        I_HW_RESET_N = 1'b1;
        I_SENSE_VALID = 1'b0;
        I_SLEEP = 1'b0;
        I_SENSE_TICKS = '0;
        cyc(12);
        t_startup();
        t_btn0();
        t_btn1();
        t_slider();
        t_sleep();
        t_addr_pin();
        print_verdict();
    end
endmodule // tlq_quickstart_tb_top
`default_nettype wire
